// *** abs_pkg.sv ***
// Shared types and constants for the analog boundary-scan cells.
// Assumes one 10 MHz system clock that samples the scan port pins.
package abs_pkg;

  // Control cells, most significant first; bit order is the chain order.
  typedef struct packed {
    logic       comparator_power_off;
    logic       comparator_mux_select;
    logic       comparator_bandgap_enable;
    logic       gain_stage_clock;
    logic       gain_path_enable;
    logic       converter_high_speed;
    logic       negative_input_bandgap_select;
    logic       converter_power_on;
    logic       gain_stage_power_on;
    logic [9:0] dac_trial;
    logic       low_channel_bypass;
    logic       gain_ten_enable;
    logic       gain_twenty_enable;
    logic       negative_input_ground;
    logic       sample_hold;
    logic       internal_reference_select;
    logic [2:0] input_select_top;
  } abs_ctl_t;

  // Observe-only cells sit above the control cells in the chain.
  typedef struct packed {
    logic comparator_result;
    logic converter_compare;
  } abs_obs_t;

  localparam int CTL_W   = $bits(abs_ctl_t);
  localparam int OBS_W   = $bits(abs_obs_t);
  localparam int CHAIN_W = CTL_W + OBS_W;

  // Recommended idle levels, loaded into the update stage at reset.
  localparam abs_ctl_t CTL_SAFE = '{
    comparator_power_off          : 1'h1,
    comparator_mux_select         : 1'h0,
    comparator_bandgap_enable     : 1'h0,
    gain_stage_clock              : 1'h0,
    gain_path_enable              : 1'h0,
    converter_high_speed          : 1'h0,
    negative_input_bandgap_select : 1'h0,
    converter_power_on            : 1'h0,
    gain_stage_power_on           : 1'h0,
    dac_trial                     : 10'h200,
    low_channel_bypass            : 1'h1,
    gain_ten_enable               : 1'h0,
    gain_twenty_enable            : 1'h0,
    negative_input_ground         : 1'h0,
    sample_hold                   : 1'h1,
    internal_reference_select     : 1'h0,
    input_select_top              : 3'h0
  };

  // Register port.
  localparam int         ADDR_W      = 4;
  localparam int         DATA_W      = 32;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_UPDATE = 4'h8;

  localparam int CTRL_DRIVE_BIT  = 0;
  localparam int CTRL_SELECT_BIT = 1;
  localparam int CTRL_W          = 2;
  localparam int STAT_READY_BIT  = 2;
  localparam int STAT_BUSY_BIT   = 3;
  localparam int STAT_STATE_LSB  = 4;

  // Converter start-up: a dummy conversion and a settling wait.
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_NS     = 200;
  localparam int SETTLE_CYC    =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DUMMY_CMP     = 10;
  localparam int BUSY_CYC      =
    (DUMMY_CMP > SETTLE_CYC) ? DUMMY_CMP : SETTLE_CYC;
  localparam int CNT_W         = 4;
  localparam logic [CNT_W-1:0] BUSY_LOAD = CNT_W'(BUSY_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;

  // Test access port states, Gray coded along the data-register path.
  typedef enum logic [3:0] {
    TAP_RESET      = 4'h0,
    TAP_IDLE       = 4'h1,
    TAP_SEL_DR     = 4'h3,
    TAP_CAPTURE_DR = 4'h2,
    TAP_SHIFT_DR   = 4'h6,
    TAP_EXIT1_DR   = 4'h7,
    TAP_PAUSE_DR   = 4'h5,
    TAP_EXIT2_DR   = 4'h4,
    TAP_UPDATE_DR  = 4'hc,
    TAP_SEL_IR     = 4'hd,
    TAP_CAPTURE_IR = 4'hf,
    TAP_SHIFT_IR   = 4'he,
    TAP_EXIT1_IR   = 4'ha,
    TAP_PAUSE_IR   = 4'hb,
    TAP_EXIT2_IR   = 4'h9,
    TAP_UPDATE_IR  = 4'h8
  } abs_tap_t;

endpackage : abs_pkg

// *** abs_scan_cells.sv ***
// Boundary-scan cells on the digital/analog edge of the comparator and
// the converter, with a small register port for software.
// Assumes scan pins are asynchronous and sampled by the 10 MHz clock,
// and that the functional control values come from logic on ref_clk_i.
//
// Notes on behaviour
// - Every analog control and observe signal has a cell.
// - Comparator-off high powers comparator down; idle 1.
// - Comparator result observed, forwarded, reads 0 idle; only the forwarded output is masked, cell and status read it raw.
// - Mux select routes converter mux; idle 0.
// - Gain-stage clock driven by scan; idle 0.
// - Gain path enable high connects stages; idle 0.
// - High-speed input speeds comparator; idle 0.
// - Bandgap as negative comparator input; idle 0.
// - Converter power-on high powers converter; idle 0.
// - Gain-stage power-on powers amplifiers; idle 0.
// - Ten-bit trial value; idle is 0x200.
// - Channels 0 to 3 bypass gain; idle 1.
// - Ground negative comparator input; idle 0.
// - Sample when low, hold when high; idle 1.
// - Bandgap as converter reference; idle 0.
// - Converter enable starts ten-comparison dummy conversion.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ns
module abs_scan_cells (
  input  wire logic                        ref_clk_i,
  input  wire logic                        reset_i,
  input  wire logic                        tck_i,
  input  wire logic                        tms_i,
  input  wire logic                        tdi_i,
  output logic                             tdo_o,
  output logic                             tdo_oe_n_o,
  input  wire abs_pkg::abs_ctl_t           func_ctl_i,
  input  wire abs_pkg::abs_obs_t           ana_obs_i,
  output abs_pkg::abs_ctl_t                analog_ctl_o,
  output logic                             comparator_result_o,
  output logic                             converter_ready_o,
  input  wire logic [abs_pkg::ADDR_W-1:0]  reg_addr_i,
  input  wire logic [abs_pkg::DATA_W-1:0]  reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [abs_pkg::DATA_W-1:0]  reg_rdata_o
);

  localparam int CW = abs_pkg::CHAIN_W;
  localparam int KW = abs_pkg::CTL_W;

  // Scan port strobes in the system clock domain.
  logic              capture;
  logic              shift;
  logic              update;
  logic              tck_fall;
  logic              tdi_s;
  abs_pkg::abs_tap_t tap_state;

  abs_tap u_tap (
    .ref_clk_i  (ref_clk_i),
    .reset_i    (reset_i),
    .tck_i      (tck_i),
    .tms_i      (tms_i),
    .tdi_i      (tdi_i),
    .capture_o  (capture),
    .shift_o    (shift),
    .update_o   (update),
    .tck_fall_o (tck_fall),
    .tdi_o      (tdi_s),
    .state_o    (tap_state)
  );

  // Analog outputs are not on this clock, so they are synchronised.
  abs_pkg::abs_obs_t obs_s;

  abs_sync #(.W(abs_pkg::OBS_W)) u_obs_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   (ana_obs_i),
    .sync_o    (obs_s)
  );

  // Control and status state.
  logic [abs_pkg::CTRL_W-1:0]  ctrl_r;
  logic [CW-1:0]               chain_r;
  logic [CW-1:0]               chain_nxt;
  abs_pkg::abs_ctl_t           update_r;
  abs_pkg::abs_ctl_t           update_nxt;
  abs_pkg::abs_ctl_t           analog_r;
  abs_pkg::abs_ctl_t           analog_nxt;
  logic                        tdo_r;
  logic                        tdo_nxt;
  logic                        tdo_oe_n_r;
  logic                        tdo_oe_n_nxt;
  logic                        result_r;
  logic                        result_nxt;
  logic                        pwr_q_r;
  logic [abs_pkg::CNT_W-1:0]   busy_cnt_r;
  logic [abs_pkg::CNT_W-1:0]   busy_cnt_nxt;
  logic                        ready_r;
  logic                        ready_nxt;
  logic [abs_pkg::DATA_W-1:0]  rdata_r;
  logic [abs_pkg::DATA_W-1:0]  rdata_nxt;

  // Register decode.
  wire sel_ctrl   = reg_addr_i == abs_pkg::ADDR_CTRL;
  wire sel_status = reg_addr_i == abs_pkg::ADDR_STATUS;
  wire sel_update = reg_addr_i == abs_pkg::ADDR_UPDATE;
  wire wr_ctrl    = reg_wr_i && sel_ctrl;
  wire wr_update  = reg_wr_i && sel_update;

  wire chain_sel  = ctrl_r[abs_pkg::CTRL_SELECT_BIT];
  wire scan_drive = ctrl_r[abs_pkg::CTRL_DRIVE_BIT];

  // Cells see the port only while software has the chain selected.
  wire do_capture = capture && chain_sel;
  wire do_shift   = shift && chain_sel;
  wire do_update  = update && chain_sel;

  // Parallel capture word: observe cells on top, then control cells.
  // Control cells capture what the digital side currently asks for.
  wire [CW-1:0] capture_word = {obs_s, func_ctl_i};

  // One general cell per chain bit: capture, shift toward the output.
  genvar gi;
  generate
    for (gi = 0; gi < CW; gi++) begin : g_cell
      wire shift_in;
      // The last cell takes the scan input; no chain bit sits above it.
      if (gi == CW - 1) begin : g_top
        assign shift_in = tdi_s;
      end else begin : g_low
        assign shift_in = chain_r[gi + 1];
      end
      assign chain_nxt[gi] = do_capture ? capture_word[gi] :
                             do_shift   ? shift_in :
                                          chain_r[gi];
    end
  endgenerate

  // The update stage changes only on update, so analog controls never
  // see the ripple of a shift in progress. Software may preload it.
  assign update_nxt = do_update ? abs_pkg::abs_ctl_t'(chain_r[KW-1:0]) :
                      wr_update ? abs_pkg::abs_ctl_t'(reg_wdata_i[KW-1:0]) :
                                  update_r;

  // Analog controls follow the scan update stage when scan drives them.
  assign analog_nxt = scan_drive ? update_r :
                                   func_ctl_i;

  // The comparator result goes to the program; it is held low from the cycle
  // after the comparator is powered down.
  assign result_nxt = obs_s.comparator_result &
                      ~analog_r.comparator_power_off;

  // Converter start-up: a dummy conversion of ten comparisons or the
  // settling time, whichever is longer, before the converter is ready.
  wire pwr_on   = analog_r.converter_power_on;
  wire pwr_rise = pwr_on & ~pwr_q_r;
  wire busy     = busy_cnt_r != abs_pkg::CNT_ZERO;
  assign busy_cnt_nxt =
    !pwr_on  ? abs_pkg::CNT_ZERO :
    pwr_rise ? abs_pkg::BUSY_LOAD :
    busy     ? busy_cnt_r - 4'h1 :
               busy_cnt_r;
  assign ready_nxt = pwr_on && !pwr_rise &&
                     (busy_cnt_nxt == abs_pkg::CNT_ZERO);

  // Test data out changes on the falling test clock during shifting and
  // floats otherwise, so other chains can share the pin.
  wire in_shift   = chain_sel && (tap_state == abs_pkg::TAP_SHIFT_DR);
  wire tdo_launch = tck_fall && in_shift;
  assign tdo_nxt      = tdo_launch ? chain_r[0] : tdo_r;
  assign tdo_oe_n_nxt = tck_fall ? ~in_shift : tdo_oe_n_r;

  // Read data. Status fields sit at their named bit positions; spare
  // bits read as zero so later additions stay compatible.
  localparam int SL = abs_pkg::STAT_STATE_LSB;
  localparam int SW = $bits(abs_pkg::abs_tap_t);

  wire [abs_pkg::DATA_W-1:0] status_word;
  wire [abs_pkg::DATA_W-1:0] ctrl_word;
  wire [abs_pkg::DATA_W-1:0] update_word;

  assign status_word[abs_pkg::OBS_W-1:0]      = obs_s;
  assign status_word[abs_pkg::STAT_READY_BIT] = ready_r;
  assign status_word[abs_pkg::STAT_BUSY_BIT]  = busy;
  assign status_word[SL+SW-1:SL]              = tap_state;
  assign status_word[abs_pkg::DATA_W-1:SL+SW] = '0;
  assign ctrl_word =
    {{(abs_pkg::DATA_W - abs_pkg::CTRL_W){1'h0}}, ctrl_r};
  assign update_word =
    {{(abs_pkg::DATA_W - KW){1'h0}}, update_r};

  assign rdata_nxt =
    !reg_rd_i  ? '0 :
    sel_ctrl   ? ctrl_word :
    sel_status ? status_word :
    sel_update ? update_word :
                 '0;

  // Software selects the chain and the drive source here.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctrl_r <= '0;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata_i[abs_pkg::CTRL_W-1:0];
    end
  end

  // The chain holds its value between test clock edges.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      chain_r <= '0;
    end else begin
      chain_r <= chain_nxt;
    end
  end

  // Both stages leave reset at the recommended idle levels; the analog stage
  // then follows func_ctl_i from the next cycle unless software selects scan drive.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      update_r <= abs_pkg::CTL_SAFE;
    end else begin
      update_r <= update_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      analog_r <= abs_pkg::CTL_SAFE;
    end else begin
      analog_r <= analog_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tdo_r <= 1'h0;
    end else begin
      tdo_r <= tdo_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tdo_oe_n_r <= 1'h1;
    end else begin
      tdo_oe_n_r <= tdo_oe_n_nxt;
    end
  end

  // Observe path toward the running program.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      result_r <= 1'h0;
    end else begin
      result_r <= result_nxt;
    end
  end

  // Start-up state restarts on every power cycle of the converter.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pwr_q_r <= 1'h0;
    end else begin
      pwr_q_r <= pwr_on;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      busy_cnt_r <= abs_pkg::CNT_ZERO;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ready_r <= 1'h0;
    end else begin
      ready_r <= ready_nxt;
    end
  end

  // Read data stand for one cycle only and are zero otherwise.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign tdo_o               = tdo_r;
  assign tdo_oe_n_o          = tdo_oe_n_r;
  assign analog_ctl_o        = analog_r;
  assign comparator_result_o = result_r;
  assign converter_ready_o   = ready_r;
  assign reg_rdata_o         = rdata_r;

endmodule : abs_scan_cells

// *** abs_scan_cells_properties.sv ***
// Port checks for the analog boundary-scan cells.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
module abs_scan_cells_properties (
  input wire logic              ref_clk_i,
  input wire logic              reset_i,
  input wire logic              tck_i,
  input wire logic              tms_i,
  input wire logic              tdi_i,
  input wire logic              tdo_o,
  input wire logic              tdo_oe_n_o,
  input wire abs_pkg::abs_ctl_t func_ctl_i,
  input wire abs_pkg::abs_obs_t ana_obs_i,
  input wire abs_pkg::abs_ctl_t analog_ctl_o,
  input wire logic              comparator_result_o,
  input wire logic              converter_ready_o,
  input wire logic [3:0]        reg_addr_i,
  input wire logic [31:0]       reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [31:0]       reg_rdata_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic pwr;
  logic off;
  assign pwr = analog_ctl_o.converter_power_on;
  assign off = analog_ctl_o.comparator_power_off;
  sequence s_pwr_rise;
    $rose(pwr);
  endsequence
  sequence s_pwr_held;
    pwr [*8] ##1 pwr [*6];
  endsequence
  chk_reset_idle: assert property (
    $fell(reset_i) |-> analog_ctl_o == abs_pkg::CTL_SAFE &&
    !comparator_result_o && tdo_oe_n_o && !converter_ready_o)
    else $error("outputs not idle after reset");
  chk_result_quiet: assert property (
    off && $past(off) |-> !comparator_result_o)
    else $error("result seen while comparator off");
  chk_ready_late: assert property (
    s_pwr_rise |-> !converter_ready_o [*8])
    else $error("converter ready too early");
  chk_ready_due: assert property (
    s_pwr_rise ##0 s_pwr_held |-> converter_ready_o)
    else $error("converter ready too late");
  chk_ready_power: assert property (
    converter_ready_o |-> $past(pwr))
    else $error("ready without converter power");
  chk_shift_hold: assert property (
    !tdo_oe_n_o && $stable(func_ctl_i) |=> $stable(analog_ctl_o))
    else $error("control changed during shift");
  chk_rdata_idle: assert property (
    !reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside read cycle");
  chk_status_ready: assert property (
    reg_rd_i && reg_addr_i == abs_pkg::ADDR_STATUS &&
    $stable(converter_ready_o) |=>
    reg_rdata_o[2] == $past(converter_ready_o))
    else $error("status ready bit wrong");
endmodule : abs_scan_cells_properties

bind abs_scan_cells abs_scan_cells_properties u_chk (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .tck_i(tck_i),
  .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
  .func_ctl_i(func_ctl_i), .ana_obs_i(ana_obs_i),
  .analog_ctl_o(analog_ctl_o), .comparator_result_o(comparator_result_o),
  .converter_ready_o(converter_ready_o), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o));

// *** abs_scan_tester.sv ***
// Behavioural scan-port controller on the far side of the chain.
// Assumes ref_clk_i is the bench clock; the test clock runs in frames only.
`timescale 1ns/1ns
module abs_scan_tester (
  input  wire logic ref_clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_n_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  logic line;
  // A released data line floats up to its pull-up level.
  assign line = tdo_oe_n_i ? 1'h1 : tdo_i;
  initial begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tdi_o = 1'h0;
  end
  // Low for 5 cycles and high for 3 gives 800 ns; the long low phase lets
  // the sampled output settle before the rise that reads it.
  task automatic tick(input logic ms, input logic di, output logic seen);
    @(posedge ref_clk_i);
    tck_o <= 1'h0;
    tms_o <= ms;
    tdi_o <= di;
    repeat (5) @(posedge ref_clk_i);
    seen = line;
    tck_o <= 1'h1;
    repeat (2) @(posedge ref_clk_i);
  endtask : tick
  // One data frame from idle; bits travel least significant first.
  task automatic scan_dr(input logic [29:0] din, output logic [29:0] dout);
    logic s;
    tick(1'h0, 1'h0, s);
    tick(1'h1, 1'h0, s);
    tick(1'h0, 1'h0, s);
    tick(1'h0, 1'h0, s);
    for (int i = 0; i < 30; i++) tick(i == 29, din[i], dout[i]);
    tick(1'h1, 1'h0, s);
    tick(1'h0, 1'h0, s);
    @(posedge ref_clk_i);
    tck_o <= 1'h0;
    tdi_o <= ~din[29];
    repeat (6) @(posedge ref_clk_i);
  endtask : scan_dr
endmodule : abs_scan_tester

// *** abs_sync.sv ***
// Two-flop synchroniser for a vector of unrelated levels.
// Assumes the inputs come from outside the ref_clk_i domain.
`timescale 1ns/1ns
module abs_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule : abs_sync

// *** abs_tap.sv ***
// Test access port state machine run from sampled scan pins.
// Assumes the test clock is much slower than ref_clk_i (8x or more).
`timescale 1ns/1ns
module abs_tap (
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  input  wire logic              tck_i,
  input  wire logic              tms_i,
  input  wire logic              tdi_i,
  output logic                   capture_o,
  output logic                   shift_o,
  output logic                   update_o,
  output logic                   tck_fall_o,
  output logic                   tdi_o,
  output abs_pkg::abs_tap_t      state_o
);

  logic [2:0]        pins_s;
  logic              tck_s;
  logic              tms_s;
  logic              tck_q_r;
  logic              tck_rise;
  abs_pkg::abs_tap_t state_r;
  abs_pkg::abs_tap_t state_nxt;

  abs_sync #(.W(3)) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   ({tck_i, tms_i, tdi_i}),
    .sync_o    (pins_s)
  );

  assign tck_s      = pins_s[2];
  assign tms_s      = pins_s[1];
  assign tdi_o      = pins_s[0];
  assign tck_rise   = tck_s & ~tck_q_r;
  assign tck_fall_o = ~tck_s & tck_q_r;

  // Cells act on the test clock edges seen in the sampled domain.
  assign capture_o = tck_rise && (state_r == abs_pkg::TAP_CAPTURE_DR);
  assign shift_o   = tck_rise && (state_r == abs_pkg::TAP_SHIFT_DR);
  assign update_o  = tck_fall_o && (state_r == abs_pkg::TAP_UPDATE_DR);
  assign state_o   = state_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      abs_pkg::TAP_RESET:
        state_nxt = tms_s ? abs_pkg::TAP_RESET : abs_pkg::TAP_IDLE;
      abs_pkg::TAP_IDLE:
        state_nxt = tms_s ? abs_pkg::TAP_SEL_DR : abs_pkg::TAP_IDLE;
      abs_pkg::TAP_SEL_DR:
        state_nxt = tms_s ? abs_pkg::TAP_SEL_IR : abs_pkg::TAP_CAPTURE_DR;
      abs_pkg::TAP_CAPTURE_DR:
        state_nxt = tms_s ? abs_pkg::TAP_EXIT1_DR : abs_pkg::TAP_SHIFT_DR;
      abs_pkg::TAP_SHIFT_DR:
        state_nxt = tms_s ? abs_pkg::TAP_EXIT1_DR : abs_pkg::TAP_SHIFT_DR;
      abs_pkg::TAP_EXIT1_DR:
        state_nxt = tms_s ? abs_pkg::TAP_UPDATE_DR : abs_pkg::TAP_PAUSE_DR;
      abs_pkg::TAP_PAUSE_DR:
        state_nxt = tms_s ? abs_pkg::TAP_EXIT2_DR : abs_pkg::TAP_PAUSE_DR;
      abs_pkg::TAP_EXIT2_DR:
        state_nxt = tms_s ? abs_pkg::TAP_UPDATE_DR : abs_pkg::TAP_SHIFT_DR;
      abs_pkg::TAP_UPDATE_DR:
        state_nxt = tms_s ? abs_pkg::TAP_SEL_DR : abs_pkg::TAP_IDLE;
      abs_pkg::TAP_SEL_IR:
        state_nxt = tms_s ? abs_pkg::TAP_RESET : abs_pkg::TAP_CAPTURE_IR;
      abs_pkg::TAP_CAPTURE_IR:
        state_nxt = tms_s ? abs_pkg::TAP_EXIT1_IR : abs_pkg::TAP_SHIFT_IR;
      abs_pkg::TAP_SHIFT_IR:
        state_nxt = tms_s ? abs_pkg::TAP_EXIT1_IR : abs_pkg::TAP_SHIFT_IR;
      abs_pkg::TAP_EXIT1_IR:
        state_nxt = tms_s ? abs_pkg::TAP_UPDATE_IR : abs_pkg::TAP_PAUSE_IR;
      abs_pkg::TAP_PAUSE_IR:
        state_nxt = tms_s ? abs_pkg::TAP_EXIT2_IR : abs_pkg::TAP_PAUSE_IR;
      abs_pkg::TAP_EXIT2_IR:
        state_nxt = tms_s ? abs_pkg::TAP_UPDATE_IR : abs_pkg::TAP_SHIFT_IR;
      abs_pkg::TAP_UPDATE_IR:
        state_nxt = tms_s ? abs_pkg::TAP_SEL_DR : abs_pkg::TAP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tck_q_r <= 1'h0;
      state_r <= abs_pkg::TAP_RESET;
    end else begin
      tck_q_r <= tck_s;
      if (tck_rise) begin
        state_r <= state_nxt;
      end
    end
  end

endmodule : abs_tap

// *** test_analog_boundary_scan_cells.sv ***
// Self-checking bench for the analog boundary-scan cells.
// Assumes the tester model drives the scan pins; registers use tasks.
`timescale 1ns/1ns
module test_analog_boundary_scan_cells;
  logic              ref_clk_i       = 1'h0;
  logic              reset_i         = 1'h1;
  logic              tck;
  logic              tms;
  logic              tdi;
  logic              tdo;
  logic              tdo_oe_n;
  logic              comp_res;
  logic              ready;
  logic              wr              = 1'h0;
  logic              rd              = 1'h0;
  logic [3:0]        addr            = 4'h0;
  logic [31:0]       wdata           = 32'h0;
  logic [31:0]       rdata;
  abs_pkg::abs_ctl_t func            = '0;
  abs_pkg::abs_obs_t obs             = '0;
  abs_pkg::abs_ctl_t actl;
  int                num_errors      = 0;
  int                samples_checked = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  abs_scan_cells u_dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .func_ctl_i(func),
    .ana_obs_i(obs), .analog_ctl_o(actl), .comparator_result_o(comp_res),
    .converter_ready_o(ready), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata));

  abs_scan_tester u_tester (
    .ref_clk_i(ref_clk_i), .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n),
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : cyc
  task automatic look();
    @(negedge ref_clk_i);
  endtask : look
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge ref_clk_i);
    wr <= 1'h0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'h1;
    @(posedge ref_clk_i);
    rd <= 1'h0;
    @(negedge ref_clk_i);
    d = rdata;
  endtask : rd_reg
  task automatic results();
    $display("Checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  initial begin
    abs_pkg::abs_ctl_t f;
    abs_pkg::abs_ctl_t u;
    abs_pkg::abs_ctl_t s;
    logic [31:0]       v;
    logic [29:0]       dout;
    cyc(4);
    reset_i <= 1'h0;
    look();
    // Functional inputs are all zero here, so only reset explains these.
    chk("idle ctl", {4'h0, actl}, {4'h0, abs_pkg::CTL_SAFE});
    chk("idle result", {31'h0, comp_res}, 32'h0);
    chk("idle oe", {31'h0, tdo_oe_n}, 32'h1);
    cyc(1);
    f = abs_pkg::CTL_SAFE;
    f.comparator_power_off = 1'h0;
    f.comparator_mux_select = 1'h1;
    f.dac_trial = 10'h155;
    func <= f;
    obs <= 2'h3;
    cyc(4);
    look();
    chk("func ctl", {4'h0, actl}, {4'h0, f});
    chk("result on", {31'h0, comp_res}, 32'h1);
    cyc(1);
    f.comparator_power_off = 1'h1;
    f.converter_power_on = 1'h1;
    func <= f;
    cyc(9);
    look();
    chk("result off", {31'h0, comp_res}, 32'h0);
    chk("ready early", {31'h0, ready}, 32'h0);
    for (int k = 0; k < 8 && ready !== 1'h1; k++) look();
    look();
    chk("ready", {31'h0, ready}, 32'h1);
    if (ready !== 1'h1) results();
    rd_reg(abs_pkg::ADDR_STATUS, v);
    chk("status", v, 32'h7);
    rd_reg(4'hc, v);
    chk("unmapped", v, 32'h0);
    u = abs_pkg::CTL_SAFE;
    u.comparator_power_off = 1'h0;
    u.comparator_mux_select = 1'h1;
    wr_reg(abs_pkg::ADDR_UPDATE, {4'h0, u});
    wr_reg(abs_pkg::ADDR_CTRL, 32'h1);
    cyc(2);
    look();
    chk("preload", {4'h0, actl}, {4'h0, u});
    wr_reg(abs_pkg::ADDR_CTRL, 32'h3);
    // Hold stays high, so the trial value is free to move.
    s = abs_pkg::CTL_SAFE;
    s.comparator_power_off = 1'h0;
    s.converter_power_on = 1'h1;
    s.negative_input_ground = 1'h1;
    s.dac_trial = 10'h143;
    u_tester.scan_dr({2'h0, s}, dout);
    look();
    chk("captured", {2'h0, dout}, {2'h0, obs, f});
    chk("applied", {4'h0, actl}, {4'h0, s});
    wr_reg(abs_pkg::ADDR_CTRL, 32'h1);
    u_tester.scan_dr({2'h0, u}, dout);
    look();
    chk("deselected", {2'h0, dout}, 32'h3fff_ffff);
    chk("kept", {4'h0, actl}, {4'h0, s});
    results();
  end
endmodule : test_analog_boundary_scan_cells
